/* src/sleep_clock_power_manager.sv */
// Behaviour
// - sleep-wait write stops clock; interrupts wake
// - synthesizer keeps running during standard sleep
// - power-control write applies after two cycles
// - input-buffer-off bit powers buffer down
// - synth enable write starts synth, lock polled
// - clearing slow select switches to fast clock
// - zero write restores peripherals, fast clock
// - no-clock bit halts all internal clocking
// - ext_interrupt_zero, ext_interrupt_one or reset pin wake stop
// - ext_interrupt_zero pin clears no-clock bit in hardware
// - lock is cond 11100, busy 11101
// - reset pin falling edge clears buffer-off
module sleep_clock_power_manager
    import power_clock_pkg::*;
#(
    parameter int APPLY_CYCLES = PC_APPLY_CYCLES,
    parameter int DEAD_CYCLES = SWITCH_DEAD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic reset_pin_n,
    input wire logic pc_wr,
    input wire logic [PC_W-1:0] pc_wdata,
    output logic [PC_W-1:0] pc_rdata,
    input wire logic sleep_wr,
    input wire logic [15:0] sleep_wdata,
    input wire logic synth_ctrl_wr,
    input wire logic [15:0] synth_ctrl_wdata,
    input wire logic ins_clear_wr,
    input wire logic [15:0] ins_clear_wdata,
    input wire logic irq_pending,
    input wire logic ext_interrupt_zero,
    input wire logic ext_interrupt_one,
    input wire logic synth_lock_pin,
    input wire logic coproc_busy,
    input wire logic [4:0] branch_condition_field,
    output logic branch_condition_true,
    output logic ext_interrupt_zero_status,
    output logic core_reset,
    output logic proc_clk_enable,
    output logic clk_slow_gate,
    output logic clk_fast_gate,
    output logic synth_run,
    output logic synth_select,
    output logic input_buffer_power,
    output logic [PERIPH_PD_W-1:0] periph_power_down,
    output logic [1:0] pm_state
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] ext_interrupt_zero_s_q, ext_interrupt_one_s_q, lock_s_q, rst_s_q;
    logic ext_interrupt_zero_prev_q, ext_interrupt_one_prev_q;
    logic ext_interrupt_zero_rise, ext_interrupt_one_rise;

    always_ff @(posedge clk_sys) begin
        ext_interrupt_zero_s_q <= {ext_interrupt_zero_s_q[0], ext_interrupt_zero};
        ext_interrupt_one_s_q <= {ext_interrupt_one_s_q[0], ext_interrupt_one};
        lock_s_q <= {lock_s_q[0], synth_lock_pin};
        rst_s_q <= {rst_s_q[0], !reset_pin_n};
        ext_interrupt_zero_prev_q <= ext_interrupt_zero_s_q[1];
        ext_interrupt_one_prev_q <= ext_interrupt_one_s_q[1];
    end

    assign ext_interrupt_zero_rise = ext_interrupt_zero_s_q[1] & !ext_interrupt_zero_prev_q;
    assign ext_interrupt_one_rise = ext_interrupt_one_s_q[1] & !ext_interrupt_one_prev_q;

    // ------------------------------------------------------------
    // delayed power-control write
    // ------------------------------------------------------------
    // the write lands late so software sees the documented two-nop lag
    logic [APPLY_CYCLES-1:0] pend_v_q, pend_v_d;
    logic [PC_W-1:0] pend_data_q [APPLY_CYCLES];
    logic [PC_W-1:0] pend_data_d [APPLY_CYCLES];
    logic [PC_W-1:0] pc_q, pc_d;

    always_comb begin
        pend_v_d = {pend_v_q[APPLY_CYCLES-2:0], pc_wr};
        pend_data_d[0] = pc_wdata;
        for (int i = 1; i < APPLY_CYCLES; i++) begin
            pend_data_d[i] = pend_data_q[i-1];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pend_v_q <= '0;
        end else begin
            pend_v_q <= pend_v_d;
        end
        pend_data_q <= pend_data_d;
    end

    // ------------------------------------------------------------
    // power-control register and wake logic
    // ------------------------------------------------------------
    pm_state_type state_q, state_d;
    logic ext_interrupt_zero_stat_q, ext_interrupt_zero_stat_d;
    logic wake_stop;

    assign wake_stop = (ext_interrupt_zero_rise & pc_q[EXT_INTERRUPT_ZERO_WAKE_ENABLE_BIT]) | ext_interrupt_one_rise;

    always_comb begin
        pc_d = pc_q;
        if (sys_rst) begin
            pc_d = PC_RESET;
        end else begin
            if (pend_v_q[APPLY_CYCLES-1]) begin
                pc_d = pend_data_q[APPLY_CYCLES-1];
            end
            if (state_q == PM_STOP && wake_stop) begin
                pc_d[NO_CLOCK_BIT] = 1'b0;
            end
        end
    end

    // reset pin clears the word without waiting for a clock edge
    always_ff @(posedge clk_sys or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            pc_q <= PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    always_comb begin
        ext_interrupt_zero_stat_d = ext_interrupt_zero_stat_q;
        if (ins_clear_wr && ins_clear_wdata[EXT_INTERRUPT_ZERO_STATUS_BIT]) begin
            ext_interrupt_zero_stat_d = 1'b0;
        end
        if (ext_interrupt_zero_rise) begin
            ext_interrupt_zero_stat_d = 1'b1;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            PM_RUN: begin
                if (pc_d[NO_CLOCK_BIT]) begin
                    state_d = PM_STOP;
                end else if (sleep_wr && sleep_wdata[SLEEP_WAIT_BIT]) begin
                    state_d = PM_SLEEP;
                end
            end
            PM_SLEEP: begin
                if (irq_pending || ext_interrupt_zero_rise || ext_interrupt_one_rise) begin
                    state_d = PM_RUN;
                end
            end
            PM_STOP: begin
                if (!pc_d[NO_CLOCK_BIT]) begin
                    state_d = PM_RUN;
                end
            end
            default: begin
                state_d = PM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= PM_RUN;
            ext_interrupt_zero_stat_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ext_interrupt_zero_stat_q <= ext_interrupt_zero_stat_d;
        end
    end

    // ------------------------------------------------------------
    // synthesizer control
    // ------------------------------------------------------------
    logic synth_en_q, synth_en_d;
    logic synth_sel_q, synth_sel_d;

    always_comb begin
        synth_en_d = synth_en_q;
        synth_sel_d = synth_sel_q;
        if (synth_ctrl_wr) begin
            synth_en_d = synth_ctrl_wdata[SYNTH_ENABLE_BIT];
            synth_sel_d = synth_ctrl_wdata[SYNTH_SELECT_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            synth_en_q <= 1'b0;
            synth_sel_q <= 1'b0;
        end else begin
            synth_en_q <= synth_en_d;
            synth_sel_q <= synth_sel_d;
        end
    end

    // ------------------------------------------------------------
    // clock source select
    // ------------------------------------------------------------
    clock_select_if sel_if ();

    assign sel_if.want_slow = pc_q[SLOW_CLOCK_SELECT_BIT];

    glitchless_clock_select #(
        .DEAD_CYCLES(DEAD_CYCLES)
    ) u_clock_select (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .sel(sel_if.mux)
    );

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic cond_d, clk_en_d, synth_run_d;

    always_comb begin
        case (branch_condition_field)
            COND_SYNTH_LOCK: cond_d = lock_s_q[1];
            COND_COPROC_BUSY: cond_d = coproc_busy;
            default: cond_d = 1'b0;
        endcase
        clk_en_d = (state_d == PM_RUN) && sel_if.settled && !pc_d[NO_CLOCK_BIT];
        // sleep alone leaves the synthesizer running
        synth_run_d = synth_en_q && !pc_q[INPUT_BUFFER_OFF_BIT]
            && !pc_q[NO_CLOCK_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            branch_condition_true <= 1'b0;
            proc_clk_enable <= 1'b0;
            synth_run <= 1'b0;
            synth_select <= 1'b0;
            input_buffer_power <= 1'b1;
            periph_power_down <= '0;
            clk_slow_gate <= 1'b0;
            clk_fast_gate <= 1'b0;
        end else begin
            branch_condition_true <= cond_d;
            proc_clk_enable <= clk_en_d;
            synth_run <= synth_run_d;
            synth_select <= synth_sel_q && synth_run_d;
            input_buffer_power <= !pc_q[INPUT_BUFFER_OFF_BIT];
            periph_power_down <= pc_q[PERIPH_PD_LSB +: PERIPH_PD_W];
            clk_slow_gate <= sel_if.slow_gate && !pc_q[NO_CLOCK_BIT];
            clk_fast_gate <= sel_if.fast_gate && !pc_q[NO_CLOCK_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        pc_rdata <= pc_q;
        ext_interrupt_zero_status <= ext_interrupt_zero_stat_q;
        core_reset <= rst_s_q[1] | sys_rst;
        pm_state <= state_q;
    end
endmodule : sleep_clock_power_manager

/* src/power_clock_pkg.sv */
package power_clock_pkg;
    // ------------------------------------------------------------
    // power-control word layout
    // ------------------------------------------------------------
    localparam int PC_W = 16;
    localparam int INPUT_BUFFER_OFF_BIT = 15;
    localparam int SLOW_CLOCK_SELECT_BIT = 14;
    localparam int NO_CLOCK_BIT = 13;
    localparam int EXT_INTERRUPT_ZERO_WAKE_ENABLE_BIT = 12;
    localparam int PERIPH_PD_LSB = 4;
    localparam int PERIPH_PD_W = 4;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    // ------------------------------------------------------------
    // other control words
    // ------------------------------------------------------------
    localparam int SLEEP_WAIT_BIT = 15;
    localparam int SYNTH_ENABLE_BIT = 15;
    localparam int SYNTH_SELECT_BIT = 14;
    localparam int EXT_INTERRUPT_ZERO_STATUS_BIT = 4;
    localparam logic [4:0] COND_SYNTH_LOCK = 5'h1c;
    localparam logic [4:0] COND_COPROC_BUSY = 5'h1d;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int PC_APPLY_CYCLES = 2;
    localparam int SWITCH_DEAD_CYCLES = 2;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_SLEEP,
        PM_STOP
    } pm_state_type;
endpackage : power_clock_pkg

/* src/clock_select_if.sv */
interface clock_select_if;
    logic want_slow;
    logic slow_gate;
    logic fast_gate;
    logic settled;

    modport ctrl (
        output want_slow,
        input slow_gate,
        input fast_gate,
        input settled
    );
    modport mux (
        input want_slow,
        output slow_gate,
        output fast_gate,
        output settled
    );
endinterface : clock_select_if

/* src/glitchless_clock_select.sv */
module glitchless_clock_select
    import power_clock_pkg::*;
#(
    parameter int DEAD_CYCLES = SWITCH_DEAD_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    clock_select_if.mux sel
);
    // ------------------------------------------------------------
    // break-before-make: both gates low for a dead time, so
    // no runt pulse reaches the processor clock
    // ------------------------------------------------------------
    logic cur_slow_q, cur_slow_d;
    logic slow_q, slow_d;
    logic fast_q, fast_d;
    logic [3:0] dead_q, dead_d;

    always_comb begin
        cur_slow_d = cur_slow_q;
        slow_d = slow_q;
        fast_d = fast_q;
        dead_d = dead_q;
        if (sel.want_slow != cur_slow_q) begin
            slow_d = 1'b0;
            fast_d = 1'b0;
            cur_slow_d = sel.want_slow;
            dead_d = 4'(DEAD_CYCLES);
        end else if (dead_q != 4'h0) begin
            dead_d = dead_q - 4'h1;
        end else begin
            slow_d = cur_slow_q;
            fast_d = !cur_slow_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cur_slow_q <= 1'b0;
            slow_q <= 1'b0;
            fast_q <= 1'b1;
            dead_q <= 4'h0;
        end else begin
            cur_slow_q <= cur_slow_d;
            slow_q <= slow_d;
            fast_q <= fast_d;
            dead_q <= dead_d;
        end
    end

    assign sel.slow_gate = slow_q;
    assign sel.fast_gate = fast_q;
    assign sel.settled = slow_q | fast_q;
endmodule : glitchless_clock_select

/* tb/sleep_clock_power_manager_monitor.sv */
module power_manager_monitor
    import power_clock_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [15:0] pc_rdata,
    input wire logic sleep_wr,
    input wire logic [15:0] sleep_wdata,
    input wire logic pc_wr,
    input wire logic [15:0] pc_wdata,
    input wire logic irq_pending,
    input wire logic ext_interrupt_zero,
    input wire logic ext_interrupt_one,
    input wire logic coproc_busy,
    input wire logic [4:0] branch_condition_field,
    input wire logic branch_condition_true,
    input wire logic proc_clk_enable,
    input wire logic clk_slow_gate,
    input wire logic clk_fast_gate,
    input wire logic input_buffer_power,
    input wire logic [3:0] periph_power_down,
    input wire logic [1:0] pm_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // write lands two edges later, its registered copy one more edge after that
    AST_PC_APPLY: assert property (pc_wr && !pc_wdata[13] |-> ##4 pc_rdata == $past(pc_wdata, 4))
        else $error("power word not applied on time");
    AST_BUF_OFF: assert property (input_buffer_power == !pc_rdata[15])
        else $error("input buffer power mismatch");
    AST_PERIPH: assert property (periph_power_down == pc_rdata[7:4])
        else $error("peripheral power-down mismatch");
    // clock enable runs one edge ahead of the registered word copy
    AST_STOP_HALT: assert property (pc_rdata[13] |->
        !$past(proc_clk_enable) && !clk_slow_gate && !clk_fast_gate) else $error("clock runs in stop");
    AST_EXT_INTERRUPT_ZERO_WAKE: assert property (pm_state == PM_STOP && pc_rdata[12] &&
        $rose(ext_interrupt_zero) |-> ##[1:8] !pc_rdata[13]) else $error("ext_interrupt_zero did not wake");
    AST_EXT_INTERRUPT_ONE_WAKE: assert property (pm_state == PM_STOP && $rose(ext_interrupt_one)
        |-> ##[1:8] pm_state == PM_RUN) else $error("ext_interrupt_one did not wake");
    AST_SLEEP: assert property (sleep_wr && sleep_wdata[15] && pm_state == PM_RUN
        && !pc_rdata[13] |=> !proc_clk_enable) else $error("sleep did not stop clock");
    AST_IRQ_WAKE: assert property (pm_state == PM_SLEEP && irq_pending |=> proc_clk_enable)
        else $error("interrupt did not wake sleep");
    AST_COND: assert property (branch_condition_field == COND_COPROC_BUSY |=>
        branch_condition_true == $past(coproc_busy)) else $error("busy condition wrong");
    AST_ONE_GATE: assert property (!(clk_slow_gate && clk_fast_gate))
        else $error("both clock gates open");
endmodule : power_manager_monitor

bind sleep_clock_power_manager power_manager_monitor mon (.clk_sys, .sys_rst, .pc_rdata,
    .sleep_wr, .sleep_wdata, .pc_wr, .pc_wdata, .irq_pending, .ext_interrupt_zero,
    .ext_interrupt_one, .coproc_busy, .branch_condition_field, .branch_condition_true,
    .proc_clk_enable, .clk_slow_gate, .clk_fast_gate, .input_buffer_power,
    .periph_power_down, .pm_state);

/* tb/sleep_clock_power_manager_tb_top.sv */
module sleep_clock_power_manager_tb_top;
    import power_clock_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 0, sys_rst = 1, reset_pin_n = 1, pc_wr = 0, sleep_wr = 0;
    logic synth_ctrl_wr = 0, ins_clear_wr = 0, irq_pending = 0, ext_interrupt_zero = 0;
    logic ext_interrupt_one = 0, synth_lock_pin = 0, coproc_busy = 0;
    logic [15:0] pc_wdata = 0, sleep_wdata = 0, synth_ctrl_wdata = 0, ins_clear_wdata = 0;
    logic [4:0] branch_condition_field = 0;
    logic [15:0] pc_rdata;
    logic [3:0] periph_power_down;
    logic [1:0] pm_state;
    logic branch_condition_true, ext_interrupt_zero_status, core_reset, proc_clk_enable;
    logic clk_slow_gate, clk_fast_gate, synth_run, synth_select, input_buffer_power;
    int miscompares = 0, checks = 0;

    sleep_clock_power_manager uut (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n),
        .pc_wr(pc_wr),
        .pc_wdata(pc_wdata),
        .pc_rdata(pc_rdata),
        .sleep_wr(sleep_wr),
        .sleep_wdata(sleep_wdata),
        .synth_ctrl_wr(synth_ctrl_wr),
        .synth_ctrl_wdata(synth_ctrl_wdata),
        .ins_clear_wr(ins_clear_wr),
        .ins_clear_wdata(ins_clear_wdata),
        .irq_pending(irq_pending),
        .ext_interrupt_zero(ext_interrupt_zero),
        .ext_interrupt_one(ext_interrupt_one),
        .synth_lock_pin(synth_lock_pin),
        .coproc_busy(coproc_busy),
        .branch_condition_field(branch_condition_field),
        .branch_condition_true(branch_condition_true),
        .ext_interrupt_zero_status(ext_interrupt_zero_status),
        .core_reset(core_reset),
        .proc_clk_enable(proc_clk_enable),
        .clk_slow_gate(clk_slow_gate),
        .clk_fast_gate(clk_fast_gate),
        .synth_run(synth_run),
        .synth_select(synth_select),
        .input_buffer_power(input_buffer_power),
        .periph_power_down(periph_power_down),
        .pm_state(pm_state)
    );

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic wt(int n);
        repeat (n) @(negedge clk_sys);
    endtask : wt
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic chb(string n, logic e, logic g);
        chk(n, {15'h0, e}, {15'h0, g});
    endtask : chb
    task automatic pw(logic [15:0] d);
        pc_wdata = d;
        pc_wr = 1;
        wt(1);
        pc_wr = 0;
    endtask : pw
    task automatic syw(logic [15:0] d);
        synth_ctrl_wdata = d;
        synth_ctrl_wr = 1;
        wt(1);
        synth_ctrl_wr = 0;
        wt(3);
    endtask : syw
    task automatic nap();
        sleep_wdata = 16'h8000;
        sleep_wr = 1;
        wt(1);
        sleep_wr = 0;
        wt(2);
        chk("sleep state", 16'(PM_SLEEP), 16'(pm_state));
        chb("sleep clk", 1'b0, proc_clk_enable);
    endtask : nap
    task automatic give_verdict();
        if (miscompares == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        wt(16);
        sys_rst = 0;
        wt(4);
        chk("reset word", 16'h0000, pc_rdata);
        // start with the synthesizer up so that disabling it is visible
        syw(16'hE9F2);
        chb("synth up", 1'b1, synth_run);
        chb("synth sel", 1'b1, synth_select);
        pw(16'h40F0);
        wt(1);
        chk("word early", 16'h0000, pc_rdata);
        wt(2);
        chk("word slow", 16'h40F0, pc_rdata);
        chk("periph off", 16'h000F, {12'h0, periph_power_down});
        wt(6);
        chb("slow gate", 1'b1, clk_slow_gate);
        chb("fast gate off", 1'b0, clk_fast_gate);
        syw(16'h29F2);
        chb("synth off", 1'b0, synth_run);
        chb("synth desel", 1'b0, synth_select);
        pw(16'hC0F0);
        wt(4);
        chb("buf off", 1'b0, input_buffer_power);
        nap();
        irq_pending = 1;
        wt(2);
        chb("irq wake", 1'b1, proc_clk_enable);
        irq_pending = 0;
        pw(16'h40F0);
        wt(4);
        chb("buf on", 1'b1, input_buffer_power);
        syw(16'hE9F2);
        chb("synth on", 1'b1, synth_run);
        synth_lock_pin = 1;
        coproc_busy = 1;
        branch_condition_field = COND_SYNTH_LOCK;
        wt(5);
        chb("lock cond", 1'b1, branch_condition_true);
        branch_condition_field = COND_COPROC_BUSY;
        wt(2);
        chb("busy cond", 1'b1, branch_condition_true);
        nap();
        chb("synth sleep", 1'b1, synth_run);
        irq_pending = 1;
        wt(2);
        irq_pending = 0;
        pw(16'h00F0);
        wt(8);
        chb("fast gate", 1'b1, clk_fast_gate);
        pw(16'h0000);
        wt(4);
        chk("all on", 16'h0000, {12'h0, periph_power_down});
        // full stop in the required order, at least two idle cycles between writes
        pw(16'h4000);
        wt(2);
        syw(16'h29F2);
        pw(16'hD000);
        wt(2);
        pw(16'hF000);
        wt(5);
        chk("stop", 16'(PM_STOP), 16'(pm_state));
        chb("stop clk", 1'b0, proc_clk_enable);
        ext_interrupt_zero = 1;
        wt(9);
        chk("ext_interrupt_zero word", 16'hD000, pc_rdata);
        chb("ext_interrupt_zero flag", 1'b1, ext_interrupt_zero_status);
        ext_interrupt_zero = 0;
        pw(16'h4000);
        ins_clear_wdata = 16'h0010;
        ins_clear_wr = 1;
        wt(1);
        ins_clear_wr = 0;
        wt(2);
        chb("ext_interrupt_zero clr", 1'b0, ext_interrupt_zero_status);
        pw(16'hE000);
        wt(5);
        ext_interrupt_zero = 1;
        wt(9);
        chk("ext_interrupt_zero ignored", 16'(PM_STOP), 16'(pm_state));
        ext_interrupt_one = 1;
        wt(9);
        chk("ext_interrupt_one wake", 16'(PM_RUN), 16'(pm_state));
        reset_pin_n = 0;
        wt(4);
        chk("pin clear", 16'h0000, pc_rdata);
        chb("pin buf on", 1'b1, input_buffer_power);
        chb("core reset", 1'b1, core_reset);
        give_verdict();
    end

    initial begin
        #20000;
        miscompares++;
        give_verdict();
    end
endmodule : sleep_clock_power_manager_tb_top
